// ==== core/cgc_pkg.sv ====
// Constants, types and register map of the clock generator control registers.
// Assumes a single 200 MHz system clock and an APB master with 32-bit data.
package cgc_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] CGC_OFF_SRC_CTL  = 8'h00;
  localparam logic [7:0] CGC_OFF_DIV_CTL  = 8'h04;
  localparam logic [7:0] CGC_OFF_LOOP_CTL = 8'h08;
  localparam logic [7:0] CGC_OFF_STATUS   = 8'h0c;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] CGC_RST_SRC_CTL  = 8'h04;
  localparam logic [7:0] CGC_RST_DIV_CTL  = 8'h40;
  localparam logic [7:0] CGC_RST_LOOP_CTL = 8'h00;

  // ************************************************************
  // Field positions of clock_source_control
  // ************************************************************
  localparam int CGC_SCLK_LSB  = 6;
  localparam int CGC_REFDIV_LSB = 3;
  localparam int CGC_REFSEL_BIT = 2;
  localparam int CGC_IRCEN_BIT = 1;
  localparam int CGC_IRSTK_BIT = 0;

  // ************************************************************
  // Field positions of divider_oscillator_control
  // ************************************************************
  localparam int CGC_BUSDIV_LSB = 6;
  localparam int CGC_RANGE_BIT = 5;
  localparam int CGC_GAIN_BIT  = 4;
  localparam int CGC_LPB_BIT   = 3;
  localparam int CGC_XSRC_BIT  = 2;
  localparam int CGC_ERCEN_BIT = 1;
  localparam int CGC_ERSTK_BIT = 0;

  // ************************************************************
  // Loop control and status fields
  // ************************************************************
  localparam int CGC_LOOPSEL_BIT = 0;
  localparam int CGC_STAT_REF    = 0;
  localparam int CGC_STAT_LOCK   = 1;

  // ************************************************************
  // System clock source encodings
  // ************************************************************
  localparam logic [1:0] CGC_SRC_LOOP = 2'h0;
  localparam logic [1:0] CGC_SRC_INT  = 2'h1;
  localparam logic [1:0] CGC_SRC_EXT  = 2'h2;

  localparam int CGC_SYNC_DEPTH = 2;

  typedef enum logic [2:0] {
    CGC_FEI, CGC_FEE, CGC_FBI, CGC_FBE, CGC_PEE, CGC_PBE, CGC_BLPI, CGC_BLPE
  } cgc_mode_t;

  typedef struct packed {
    logic high_range;
    logic high_gain;
    logic osc_request;
  } cgc_osc_ctl_t;

endpackage

// ==== core/cgc_ctrl.sv ====
// Clock generator control registers: source/divider selection, reference gating and lock.
// Assumes an APB master on CLK_SYS; reference and loop clocks arrive as raw levels.
//
// Contract
// - Source field 00 loop, 01 internal, 10 external; 11 acts as 00.
// - Reference divider divides by two to the field value; resets to 000.
// - Reference divider input is the reference chosen by the select bit.
// - Reference select bit 2 set picks internal, clear picks external reference.
// - Internal output enable bit 1 makes the internal reference output active.
// - In stop, internal reference kept only with stop-keep and enable or FEI/FBI/BLPI.
// - Bus divider divides source by 1, 2, 4, 8; resets to 01.
// - Range bit 5 selects high or low oscillator frequency range.
// - Gain bit 4 selects high-gain or low-power oscillator operation.
// - Low-power bit 3 stops the loop in bypassed modes.
// - Source bit 2 requests crystal oscillator when set, external clock when clear.
// - External output enable bit 1 makes the external reference output active.
// - In stop, external reference kept only with stop-keep and enable or FEE/FBE/PEE/PBE/BLPE.
// - No signal of the generator leaves the chip; all ports are internal.
// - Changing select, loop or reference divider while locked clears lock until reacquired.
// - Reference status follows the select bit only after synchronization.
module cgc_ctrl #(
  parameter int SYNC_DEPTH = cgc_pkg::CGC_SYNC_DEPTH
) (
  // Clock and reset.
  input  wire logic                 CLK_SYS,
  input  wire logic                 RSTN,
  // APB slave.
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [7:0]           PADDR,
  input  wire logic [31:0]          PWDATA,
  output logic      [31:0]          PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR,
  // Raw clocks and lock detect from the analog side.
  input  wire logic                 INT_REF_CLK,
  input  wire logic                 EXT_REF_CLK,
  input  wire logic                 LOOP_CLK,
  input  wire logic                 LOCK_DETECT,
  // Mode sequencer, same clock domain.
  input  wire cgc_pkg::cgc_mode_t   MODE,
  input  wire logic                 STOP_MODE,
  // Controls towards clock tree and oscillator.
  output cgc_pkg::cgc_osc_ctl_t     OSC_CTL,
  output logic                      INTERNAL_REF_CLOCK_OUT_EN,
  output logic                      INTERNAL_REF_RUN,
  output logic                      EXTERNAL_REF_CLOCK_OUT_EN,
  output logic                      EXTERNAL_REF_RUN,
  output logic                      LOOP_EN,
  output logic                      REF_TICK,
  output logic                      SYS_TICK,
  output logic                      LOCK,
  output logic                      REFERENCE_SOURCE_STATUS
);
  import cgc_pkg::*;

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (SYNC_DEPTH < 2) begin : g_bad_depth
    $error("SYNC_DEPTH must be at least 2");
  end

  // ************************************************************
  // Input synchronisers and edge detection
  // ************************************************************
  localparam int NSYNC = 4;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync_out;
  logic [NSYNC-1:0] prev_q;
  logic [NSYNC-1:0] rise;

  assign raw_in = {LOCK_DETECT, LOOP_CLK, EXT_REF_CLK, INT_REF_CLK};

  for (genvar i = 0; i < NSYNC; i++) begin : g_sync
    logic [SYNC_DEPTH-1:0] chain_q;
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
        chain_q <= '0;
      end else begin
        chain_q <= {chain_q[SYNC_DEPTH-2:0], raw_in[i]};
      end
    end
    assign sync_out[i] = chain_q[SYNC_DEPTH-1];
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      prev_q <= '0;
    end else begin
      prev_q <= sync_out;
    end
  end

  assign rise = sync_out & ~prev_q;

  logic irc_rise;
  logic erc_rise;
  logic loop_rise;
  logic lock_det_s;
  assign irc_rise   = rise[0];
  assign erc_rise   = rise[1];
  assign loop_rise  = rise[2];
  assign lock_det_s = sync_out[3];

  // ************************************************************
  // APB slave
  // ************************************************************
  logic [7:0] src_ctl_q;
  logic [7:0] div_ctl_q;
  logic [7:0] loop_ctl_q;
  logic       lock_q;
  logic [1:0] stat_sync_q;
  logic       setup;
  logic       wr_en;
  logic       hit;
  logic [7:0] rd_byte;

  assign setup = PSEL && !PENABLE;
  assign wr_en = PSEL && PENABLE && PREADY && PWRITE;
  assign hit   = (PADDR == CGC_OFF_SRC_CTL) || (PADDR == CGC_OFF_DIV_CTL) ||
                 (PADDR == CGC_OFF_LOOP_CTL) || (PADDR == CGC_OFF_STATUS);

  always_comb begin
    case (PADDR)
      CGC_OFF_SRC_CTL:  rd_byte = src_ctl_q;
      CGC_OFF_DIV_CTL:  rd_byte = div_ctl_q;
      CGC_OFF_LOOP_CTL: rd_byte = loop_ctl_q;
      CGC_OFF_STATUS:   rd_byte = {6'h00, lock_q, stat_sync_q[1]};
      default:          rd_byte = 8'h00;
    endcase
  end

  // Ready is raised for exactly the first access cycle, giving zero wait states.
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= setup;
      PSLVERR <= setup && !hit;
      if (setup && !PWRITE) begin
        PRDATA <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ************************************************************
  // Control registers
  // ************************************************************
  logic wr_src;
  logic wr_div;
  logic wr_loop;
  assign wr_src  = wr_en && (PADDR == CGC_OFF_SRC_CTL);
  assign wr_div  = wr_en && (PADDR == CGC_OFF_DIV_CTL);
  assign wr_loop = wr_en && (PADDR == CGC_OFF_LOOP_CTL);

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      src_ctl_q  <= CGC_RST_SRC_CTL;
      div_ctl_q  <= CGC_RST_DIV_CTL;
      loop_ctl_q <= CGC_RST_LOOP_CTL;
    end else begin
      if (wr_src) begin
        src_ctl_q <= PWDATA[7:0];
      end
      if (wr_div) begin
        div_ctl_q <= PWDATA[7:0];
      end
      if (wr_loop) begin
        loop_ctl_q <= {7'h00, PWDATA[CGC_LOOPSEL_BIT]};
      end
    end
  end

  logic [1:0] clk_src;
  logic [2:0] ref_div;
  logic       ref_int_sel;
  logic [1:0] bus_div;
  assign clk_src     = src_ctl_q[CGC_SCLK_LSB +: 2];
  assign ref_div     = src_ctl_q[CGC_REFDIV_LSB +: 3];
  assign ref_int_sel = src_ctl_q[CGC_REFSEL_BIT];
  assign bus_div     = div_ctl_q[CGC_BUSDIV_LSB +: 2];

  // ************************************************************
  // Reference divider
  // ************************************************************
  logic       ref_rise;
  logic [6:0] ref_cnt_q;
  logic [6:0] ref_mask;

  assign ref_rise = ref_int_sel ? irc_rise : erc_rise;
  assign ref_mask = 7'h7f >> (3'd7 - ref_div);

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      ref_cnt_q <= 7'h00;
      REF_TICK  <= 1'b0;
    end else begin
      REF_TICK <= ref_rise && ((ref_cnt_q & ref_mask) == ref_mask);
      if (ref_rise) begin
        ref_cnt_q <= ref_cnt_q + 7'h01;
      end
    end
  end

  // ************************************************************
  // System clock source and bus divider
  // ************************************************************
  logic       src_rise;
  logic [2:0] bus_cnt_q;
  logic [2:0] bus_mask;

  always_comb begin
    case (clk_src)
      CGC_SRC_INT: src_rise = irc_rise;
      CGC_SRC_EXT: src_rise = erc_rise;
      default:     src_rise = loop_rise;
    endcase
  end

  assign bus_mask = 3'h7 >> (2'd3 - bus_div);

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      bus_cnt_q <= 3'h0;
      SYS_TICK  <= 1'b0;
    end else begin
      SYS_TICK <= src_rise && ((bus_cnt_q & bus_mask) == bus_mask);
      if (src_rise) begin
        bus_cnt_q <= bus_cnt_q + 3'h1;
      end
    end
  end

  // ************************************************************
  // Reference gating, stop behaviour and oscillator controls
  // ************************************************************
  cgc_mode_t pre_mode_q;
  logic      irc_keep;
  logic      erc_keep;
  logic      bypassed;

  // The mode seen before stop is frozen so stop decisions use it.
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      pre_mode_q <= CGC_FEI;
    end else if (!STOP_MODE) begin
      pre_mode_q <= MODE;
    end
  end

  assign irc_keep = src_ctl_q[CGC_IRSTK_BIT] && (src_ctl_q[CGC_IRCEN_BIT] ||
                    pre_mode_q inside {CGC_FEI, CGC_FBI, CGC_BLPI});
  assign erc_keep = div_ctl_q[CGC_ERSTK_BIT] && (div_ctl_q[CGC_ERCEN_BIT] ||
                    pre_mode_q inside {CGC_FEE, CGC_FBE, CGC_PEE, CGC_PBE, CGC_BLPE});
  assign bypassed = MODE inside {CGC_FBI, CGC_FBE, CGC_PBE, CGC_BLPI, CGC_BLPE};

  // All controls are internal nets; none is meant for a package pin.
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      INTERNAL_REF_RUN          <= 1'b1;
      EXTERNAL_REF_RUN          <= 1'b1;
      INTERNAL_REF_CLOCK_OUT_EN <= 1'b0;
      EXTERNAL_REF_CLOCK_OUT_EN <= 1'b0;
      LOOP_EN                   <= 1'b1;
      OSC_CTL                   <= '0;
    end else begin
      INTERNAL_REF_RUN <= !STOP_MODE || irc_keep;
      EXTERNAL_REF_RUN <= !STOP_MODE || erc_keep;
      INTERNAL_REF_CLOCK_OUT_EN <= src_ctl_q[CGC_IRCEN_BIT] &&
                                   (!STOP_MODE || irc_keep);
      EXTERNAL_REF_CLOCK_OUT_EN <= div_ctl_q[CGC_ERCEN_BIT] &&
                                   (!STOP_MODE || erc_keep);
      LOOP_EN <= !STOP_MODE && !(div_ctl_q[CGC_LPB_BIT] && bypassed);
      OSC_CTL.high_range  <= div_ctl_q[CGC_RANGE_BIT];
      OSC_CTL.high_gain   <= div_ctl_q[CGC_GAIN_BIT];
      OSC_CTL.osc_request <= div_ctl_q[CGC_XSRC_BIT];
    end
  end

  // ************************************************************
  // Lock indication and reference status
  // ************************************************************
  logic loop_chg;
  logic relock_wait_q;

  assign loop_chg = (wr_src && ((PWDATA[CGC_REFSEL_BIT] != ref_int_sel) ||
                    (PWDATA[CGC_REFDIV_LSB +: 3] != ref_div))) ||
                    (wr_loop && (PWDATA[CGC_LOOPSEL_BIT] != loop_ctl_q[CGC_LOOPSEL_BIT]));

  // A change forces a wait for the detector to drop and rise again; the change wins.
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      relock_wait_q <= 1'b0;
      lock_q        <= 1'b0;
    end else begin
      if (loop_chg && lock_q) begin
        relock_wait_q <= 1'b1;
      end else if (!lock_det_s) begin
        relock_wait_q <= 1'b0;
      end
      lock_q <= lock_det_s && !relock_wait_q && !(loop_chg && lock_q);
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      stat_sync_q <= {2{CGC_RST_SRC_CTL[CGC_REFSEL_BIT]}};
      LOCK        <= 1'b0;
    end else begin
      stat_sync_q <= {stat_sync_q[0], ref_int_sel};
      LOCK        <= lock_q;
    end
  end

  assign REFERENCE_SOURCE_STATUS = stat_sync_q[1];

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_wr_src;
    PSEL && PENABLE && PREADY && PWRITE && (PADDR == CGC_OFF_SRC_CTL);
  endsequence

  sequence s_lock_break;
    lock_q && loop_chg;
  endsequence

  a_src_reserved: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (clk_src == 2'h3) && loop_rise && ((bus_cnt_q & bus_mask) == bus_mask) |=> SYS_TICK)
    else $error("reserved source does not follow the loop clock");

  a_ref_div_one: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (ref_div == 3'h0) && ref_rise |=> REF_TICK)
    else $error("undivided reference missed a tick");

  a_ref_sel_path: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    !ref_int_sel && irc_rise && !erc_rise |=> !REF_TICK)
    else $error("internal edge reached divider while external selected");

  a_irc_out_gate: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    !STOP_MODE |=> (INTERNAL_REF_CLOCK_OUT_EN == $past(src_ctl_q[CGC_IRCEN_BIT])))
    else $error("internal reference output enable wrong");

  a_irc_stop_off: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    STOP_MODE && !src_ctl_q[CGC_IRSTK_BIT] |=> !INTERNAL_REF_RUN && !INTERNAL_REF_CLOCK_OUT_EN)
    else $error("internal reference kept in stop without stop-keep");

  a_bus_div_one: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (bus_div == 2'h0) && src_rise |=> SYS_TICK)
    else $error("undivided bus tick missing");

  a_osc_ctl_map: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    1'b1 |=> OSC_CTL == $past({div_ctl_q[CGC_RANGE_BIT], div_ctl_q[CGC_GAIN_BIT],
                               div_ctl_q[CGC_XSRC_BIT]}))
    else $error("oscillator controls do not follow register");

  a_loop_bypass_off: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    div_ctl_q[CGC_LPB_BIT] && (MODE == CGC_BLPE) |=> !LOOP_EN)
    else $error("loop left running in low-power bypass");

  a_erc_stop_off: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    STOP_MODE && !div_ctl_q[CGC_ERSTK_BIT] |=> !EXTERNAL_REF_RUN)
    else $error("external reference kept in stop without stop-keep");

  a_lock_cleared: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    s_lock_break |=> !lock_q ##1 (!lock_q || $past(!lock_det_s, 1)))
    else $error("lock not cleared after loop setting change");

  a_ref_stat_lag: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    $changed(ref_int_sel) |-> (REFERENCE_SOURCE_STATUS != ref_int_sel) ##1
      (REFERENCE_SOURCE_STATUS != ref_int_sel || $changed(ref_int_sel)))
    else $error("reference status updated without synchronisation delay");

  a_src_readback: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    s_wr_src |=> src_ctl_q == $past(PWDATA[7:0]))
    else $error("control register did not take written byte");

endmodule

// ==== sim/cgc_tb.sv ====
// Self-checking bench for the clock generator control registers.
// Assumes cgc_pkg and cgc_ctrl are compiled first; the bench drives every port itself.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import cgc_pkg::*;

  // ************************************************************
  // Signals
  // ************************************************************
  logic         clk_sys, rstn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic         int_ref_clk, ext_ref_clk, loop_clk, lock_detect, stop_mode;
  logic         int_oe, int_run, ext_oe, ext_run, loop_en, ref_tick, sys_tick;
  logic         lock, ref_status, err, bp;
  cgc_mode_t    mode;
  cgc_osc_ctl_t osc_ctl;
  int           n_mismatch, tests_run, cyc, n_ref, n_sys, n0;
  logic [2:0]   sel [4] = '{3'h4, 3'h1, 3'h2, 3'h4};

  cgc_ctrl DUT (
    .CLK_SYS(clk_sys), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .INT_REF_CLK(int_ref_clk), .EXT_REF_CLK(ext_ref_clk), .LOOP_CLK(loop_clk),
    .LOCK_DETECT(lock_detect), .MODE(mode), .STOP_MODE(stop_mode), .OSC_CTL(osc_ctl),
    .INTERNAL_REF_CLOCK_OUT_EN(int_oe), .INTERNAL_REF_RUN(int_run),
    .EXTERNAL_REF_CLOCK_OUT_EN(ext_oe), .EXTERNAL_REF_RUN(ext_run), .LOOP_EN(loop_en),
    .REF_TICK(ref_tick), .SYS_TICK(sys_tick), .LOCK(lock),
    .REFERENCE_SOURCE_STATUS(ref_status)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ************************************************************
  // Tick counting and hang guard
  // ************************************************************
  always @(posedge clk_sys) begin
    cyc++;
    if (ref_tick === 1'b1) n_ref++;
    if (sys_tick === 1'b1) n_sys++;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string w);
    apb(1'b0, a, 32'h0);
    chk(rd, e, w);
    chk(err, 1'b0, "slave error");
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Pulses the clocks in mask m (bit 0 internal, 1 external, 2 loop) n times, slowly.
  task automatic pulse(input logic [2:0] m, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      {loop_clk, ext_ref_clk, int_ref_clk} <= m;
      repeat (4) @(posedge clk_sys);
      {loop_clk, ext_ref_clk, int_ref_clk} <= 3'h0;
      repeat (3) @(posedge clk_sys);
    end
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    {loop_clk, ext_ref_clk, int_ref_clk} = 3'h0;
    lock_detect = 1'b0;
    stop_mode = 1'b0;
    mode = CGC_FEI;
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    settle(1);
    chk(ref_status, 1'b1, "reference status at reset");
    rdchk(CGC_OFF_SRC_CTL, {24'h0, CGC_RST_SRC_CTL}, "source control reset");
    rdchk(CGC_OFF_DIV_CTL, {24'h0, CGC_RST_DIV_CTL}, "divider control reset");
    // The status bit must lag a select change by the synchroniser.
    wr(CGC_OFF_SRC_CTL, 32'h0);
    #1;
    chk(ref_status, 1'b1, "reference status before sync");
    settle(4);
    chk(ref_status, 1'b0, "reference status after sync");
    rdchk(CGC_OFF_STATUS, 32'h0, "status register");
    wr(CGC_OFF_SRC_CTL, 32'hffffff5a);
    wr(CGC_OFF_DIV_CTL, 32'hffffffa5);
    rdchk(CGC_OFF_SRC_CTL, 32'h5a, "source control readback");
    rdchk(CGC_OFF_DIV_CTL, 32'ha5, "divider control readback");
    chk(osc_ctl, 3'b101, "oscillator controls");
    chk(int_oe, 1'b1, "internal output enable");
    chk(ext_oe, 1'b0, "external output enable");
    wr(CGC_OFF_DIV_CTL, 32'h5a);
    settle(2);
    chk(osc_ctl, 3'b010, "oscillator controls");
    chk(ext_oe, 1'b1, "external output enable");
    apb(1'b1, 8'h10, 32'hff);
    chk(err, 1'b1, "unmapped write error");
    apb(1'b0, 8'h10, 32'h0);
    chk(err, 1'b1, "unmapped read error");
    chk(rd, 32'h0, "unmapped read data");
    // Selected clock gets 16 edges, the others 8, so a wrong choice changes the count.
    for (int s = 0; s < 4; s++) begin
      wr(CGC_OFF_SRC_CTL, {24'h0, s[1:0], 6'h04});
      wr(CGC_OFF_DIV_CTL, {24'h0, s[1:0], 6'h00});
      n0 = n_sys;
      pulse(sel[s], 16);
      pulse(~sel[s], 8);
      settle(8);
      chk(n_sys - n0, 16 >> s, "system ticks");
    end
    // Pass 4 selects the external reference with divide by two.
    for (int r = 0; r < 5; r++) begin
      wr(CGC_OFF_SRC_CTL, r < 4 ? {24'h0, 2'h0, r[2:0], 3'h4} : 32'h08);
      n0 = n_ref;
      pulse(r < 4 ? 3'h1 : 3'h2, 16);
      pulse(r < 4 ? 3'h2 : 3'h1, 8);
      settle(8);
      chk(n_ref - n0, r < 4 ? 16 >> r : 8, "reference ticks");
    end
    // Stop with both keep bits set and outputs off: the pre-stop mode decides.
    wr(CGC_OFF_SRC_CTL, 32'h05);
    wr(CGC_OFF_DIV_CTL, 32'h49);
    for (int m = 0; m < 8; m++) begin
      @(posedge clk_sys);
      mode <= cgc_mode_t'(m[2:0]);
      settle(3);
      bp = mode inside {CGC_FBI, CGC_FBE, CGC_PBE, CGC_BLPI, CGC_BLPE};
      chk(loop_en, !bp, "loop enable");
      @(posedge clk_sys);
      stop_mode <= 1'b1;
      settle(3);
      chk(int_run, mode inside {CGC_FEI, CGC_FBI, CGC_BLPI}, "internal run");
      bp = mode inside {CGC_FEE, CGC_FBE, CGC_PEE, CGC_PBE, CGC_BLPE};
      chk(ext_run, bp, "external run");
      @(posedge clk_sys);
      stop_mode <= 1'b0;
    end
    wr(CGC_OFF_DIV_CTL, 32'h41);
    settle(3);
    chk(loop_en, 1'b1, "loop enable in bypass");
    // Keep and enable combinations in a mode that keeps only the external side.
    @(posedge clk_sys);
    mode <= CGC_PEE;
    for (int k = 0; k < 4; k++) begin
      wr(CGC_OFF_SRC_CTL, {24'h0, 6'h01, k[1], k[0]});
      wr(CGC_OFF_DIV_CTL, {24'h0, 6'h10, k[1], k[0]});
      settle(2);
      chk(int_oe, k[1], "internal output enable");
      chk(ext_oe, k[1], "external output enable");
      @(posedge clk_sys);
      stop_mode <= 1'b1;
      settle(3);
      chk(int_run, k[0] & k[1], "internal run");
      chk(ext_run, k[0], "external run");
      @(posedge clk_sys);
      stop_mode <= 1'b0;
    end
    // Lock must drop on a reference divider or loop change and return only after a new lock.
    wr(CGC_OFF_SRC_CTL, 32'h04);
    wr(CGC_OFF_LOOP_CTL, 32'h0);
    @(posedge clk_sys);
    lock_detect <= 1'b1;
    settle(8);
    chk(lock, 1'b1, "lock");
    wr(CGC_OFF_DIV_CTL, 32'h40);
    settle(3);
    chk(lock, 1'b1, "lock kept");
    // Software keeps the divided reference inside the loop's legal band.
    wr(CGC_OFF_SRC_CTL, 32'h0c);
    settle(3);
    chk(lock, 1'b0, "lock cleared");
    settle(10);
    chk(lock, 1'b0, "lock held clear");
    @(posedge clk_sys);
    lock_detect <= 1'b0;
    settle(6);
    @(posedge clk_sys);
    lock_detect <= 1'b1;
    settle(8);
    chk(lock, 1'b1, "lock reacquired");
    wr(CGC_OFF_LOOP_CTL, 32'h1);
    settle(3);
    chk(lock, 1'b0, "lock cleared by loop change");
    rdchk(CGC_OFF_LOOP_CTL, 32'h1, "loop control readback");
    rdchk(CGC_OFF_STATUS, 32'h1, "status register");
    tally_and_finish();
  end
endmodule
